// >>> common/pdp_pkg.sv
// Shared types and constants for the divider programming block
package pdp_pkg;

  // Loading method selected by the two mode pins
  typedef enum logic [1:0] {
    PDP_MODE_PARALLEL = 2'b00,
    PDP_MODE_SERIAL   = 2'b01,
    PDP_MODE_DIRECT   = 2'b10
  } pdp_mode_e;

  // Counter setting word, first serial bit in the top position
  typedef struct packed {
    logic [1:0] r_hi;
    logic [1:0] m_hi;
    logic       bypass;
    logic [6:0] m_lo;
    logic [3:0] r_lo;
    logic [3:0] a;
  } pdp_word_s;

  // Parallel byte layouts for the three sections
  typedef struct packed {
    logic       bypass;
    logic [6:0] m_lo;
  } pdp_main_low_s;

  typedef struct packed {
    logic [3:0] unused;
    logic [1:0] r_hi;
    logic [1:0] m_hi;
  } pdp_main_high_s;

  typedef struct packed {
    logic [3:0] r_lo;
    logic [3:0] a;
  } pdp_swref_s;

  // Hardwired counter settings
  typedef struct packed {
    logic       bypass;
    logic [6:0] m_lo;
    logic [3:0] r_lo;
    logic [3:0] a;
  } pdp_direct_s;

  // Enhancement byte, first serial bit in the top position
  typedef struct packed {
    logic [2:0] reserved;
    logic       power_down;
    logic       counter_load;
    logic       modsel_out;
    logic       presc_out;
    logic       out_disable;
  } pdp_enh_s;

  // Pins crossing into the system clock
  typedef struct packed {
    logic        bus_mode;
    logic        serial_select;
    logic [7:0]  data;
    logic        main_low_wr;
    logic        main_high_wr;
    logic        swref_wr;
    logic        hop_wr;
    logic        enh_wr;
    logic        serial_load_wr;
    logic        par_pp_sel;
    logic        ser_pp_sel;
    logic        enh_enable_n;
    pdp_direct_s direct;
    logic        rf;
    logic        reference;
  } pdp_pins_s;

  localparam int        PDP_WORD_W           = 20;
  localparam int        PDP_ENH_W            = 8;
  localparam int        PDP_M_W              = 9;
  localparam int        PDP_R_W              = 6;
  localparam int        PDP_A_W              = 4;
  localparam logic [3:0] PDP_PRESC_LOW_RATIO  = 4'hA;
  localparam logic [3:0] PDP_PRESC_HIGH_RATIO = 4'hB;
  localparam logic [19:0] PDP_WORD_RST        = 20'h00000;
  localparam logic [7:0]  PDP_ENH_RST         = 8'h00;
  localparam logic [1:0]  PDP_FORCED_ZERO     = 2'h0;

endpackage

// >>> verilog/pdp_divider_core.sv
// Divider chain with serial, parallel and hardwired counter programming
//
// Behaviour
// RULE1: Prescaler divides RF input by 10 or 11 per modulus select.
// RULE2: Bypass low uses prescaler; high feeds main counter directly, prescaler idle.
// RULE3: With prescaler, main output is RF divided by 10*(M+1)+A.
// RULE4: Main count of 1 gives main counter ratio of two.
// RULE5: Bypassed, RF divides by M+1; swallow count ignored.
// RULE6: Reference divides by R+1; zero passes reference straight through.
// RULE7: Mode pins pick parallel, serial or hardwired loading.
// RULE8: Parallel strobe rising edges latch bus into matching staging section.
// RULE9: Section byte layouts for swallow/reference, main-low and main-high strobes.
// RULE10: Parallel hop strobe rising copies staging into secondary.
// RULE11: Parallel ping-pong select high uses staging, low uses secondary.
// RULE12: Parallel enhancement strobe rising latches bus into enhancement register.
// RULE13: Enhancement bits act only while enable input is low.
// RULE14: Serial mode shifts twenty bits, MSB first, on serial clock rising.
// RULE15: Serial order R5,R4,M8,M7,bypass,M6..M0,R3..R0,A3..A0.
// RULE16: Serial load or hop strobe rising copies staging into secondary.
// RULE17: Serial ping-pong select high uses staging, low uses secondary.
// RULE18: Enhancement strobe high shifts eight bits, MSB first, on serial clock.
// RULE19: Shifted enhancement bits take effect on enhancement strobe falling edge.
// RULE20: Hardwired mode takes bypass, M6..M0, R3..R0, A3..A0 from pins.
// RULE21: Hardwired mode forces M8, M7, R5, R4 to zero.
// RULE22: Enhancement bits: power down, immediate load, test routing, output disable.
// RULE23: Divide-by-11 for A prescaler cycles, then divide-by-10 to period end.
`timescale 1ns/1ps

module pdp_divider_core
  import pdp_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                sclk_i,
  input  wire logic                serial_data_i,
  input  wire logic                bus_mode_i,
  input  wire logic                serial_select_i,
  input  wire logic [7:0]          data_i,
  input  wire logic                main_low_write_strobe_i,
  input  wire logic                main_high_write_strobe_i,
  input  wire logic                swallow_ref_write_strobe_i,
  input  wire logic                hop_write_strobe_i,
  input  wire logic                enh_write_strobe_i,
  input  wire logic                serial_load_strobe_i,
  input  wire logic                parallel_pingpong_select_i,
  input  wire logic                serial_pingpong_select_i,
  input  wire logic                enh_enable_n_i,
  input  wire pdp_pkg::pdp_direct_s direct_setting_i,
  input  wire logic                rf_i,
  input  wire logic                reference_input_i,
  output logic                     main_divided_output_o,
  output logic                     comparison_output_o,
  output logic                     modulus_select_o,
  output logic                     test_output_o
);

  import pdp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic pdp_mode_e pdp_mode_of(input logic bmode, input logic smode);
    pdp_mode_e m;
    if (bmode) begin
      m = PDP_MODE_DIRECT;
    end else if (smode) begin
      m = PDP_MODE_SERIAL;
    end else begin
      m = PDP_MODE_PARALLEL;
    end
    return m;
  endfunction

  function automatic logic pdp_rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain: shift stages

  pdp_word_s shift_word_r;
  pdp_word_s shift_word_nxt;
  pdp_enh_s  shift_enh_r;
  pdp_enh_s  shift_enh_nxt;

  always_comb begin
    shift_word_nxt = shift_word_r;
    shift_enh_nxt  = shift_enh_r;
    if (!serial_load_strobe_i) begin
      if (enh_write_strobe_i) begin
        shift_enh_nxt = {shift_enh_r[PDP_ENH_W-2:0], serial_data_i}; // see RULE18
      end else begin
        shift_word_nxt = {shift_word_r[PDP_WORD_W-2:0], serial_data_i}; // see RULE14 RULE15
      end
    end
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_word_r <= PDP_WORD_RST;
      shift_enh_r  <= PDP_ENH_RST;
    end else begin
      shift_word_r <= shift_word_nxt;
      shift_enh_r  <= shift_enh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  pdp_pins_s pins_raw;
  pdp_pins_s pins_s1_r;
  pdp_pins_s pins_s2_r;
  pdp_pins_s pins_s3_r;

  always_comb begin
    pins_raw.bus_mode       = bus_mode_i;
    pins_raw.serial_select  = serial_select_i;
    pins_raw.data           = data_i;
    pins_raw.main_low_wr    = main_low_write_strobe_i;
    pins_raw.main_high_wr   = main_high_write_strobe_i;
    pins_raw.swref_wr       = swallow_ref_write_strobe_i;
    pins_raw.hop_wr         = hop_write_strobe_i;
    pins_raw.enh_wr         = enh_write_strobe_i;
    pins_raw.serial_load_wr = serial_load_strobe_i;
    pins_raw.par_pp_sel     = parallel_pingpong_select_i;
    pins_raw.ser_pp_sel     = serial_pingpong_select_i;
    pins_raw.enh_enable_n   = enh_enable_n_i;
    pins_raw.direct         = direct_setting_i;
    pins_raw.rf             = rf_i;
    pins_raw.reference      = reference_input_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_s1_r <= '0;
      pins_s2_r <= '0;
      pins_s3_r <= '0;
    end else begin
      pins_s1_r <= pins_raw;
      pins_s2_r <= pins_s1_r;
      pins_s3_r <= pins_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staging, secondary and enhancement registers

  pdp_mode_e      mode;
  pdp_main_low_s  sec_low;
  pdp_main_high_s sec_high;
  pdp_swref_s     sec_swref;
  pdp_word_s      primary_r;
  pdp_word_s      primary_nxt;
  pdp_word_s      secondary_r;
  pdp_word_s      secondary_nxt;
  pdp_enh_s       enh_r;
  pdp_enh_s       enh_nxt;
  pdp_enh_s       enh_act;
  pdp_word_s      active_r;
  pdp_word_s      active_nxt;
  logic           use_primary;

  always_comb begin
    mode          = pdp_mode_of(pins_s2_r.bus_mode, pins_s2_r.serial_select); // see RULE7
    sec_low       = pins_s2_r.data;
    sec_high      = pins_s2_r.data;
    sec_swref     = pins_s2_r.data;
    primary_nxt   = primary_r;
    secondary_nxt = secondary_r;
    enh_nxt       = enh_r;
    case (mode)
      PDP_MODE_PARALLEL: begin
        if (pdp_rise(pins_s2_r.main_low_wr, pins_s3_r.main_low_wr)) begin
          primary_nxt.bypass = sec_low.bypass; // see RULE8 RULE9
          primary_nxt.m_lo   = sec_low.m_lo; // see RULE9
        end
        if (pdp_rise(pins_s2_r.main_high_wr, pins_s3_r.main_high_wr)) begin
          primary_nxt.r_hi = sec_high.r_hi; // see RULE8 RULE9
          primary_nxt.m_hi = sec_high.m_hi; // see RULE9
        end
        if (pdp_rise(pins_s2_r.swref_wr, pins_s3_r.swref_wr)) begin
          primary_nxt.r_lo = sec_swref.r_lo; // see RULE8 RULE9
          primary_nxt.a    = sec_swref.a; // see RULE9
        end
        if (pdp_rise(pins_s2_r.hop_wr, pins_s3_r.hop_wr)) begin
          secondary_nxt = primary_r; // see RULE10
        end
        if (pdp_rise(pins_s2_r.enh_wr, pins_s3_r.enh_wr)) begin
          enh_nxt = pins_s2_r.data; // see RULE12
        end
      end
      PDP_MODE_SERIAL: begin
        if (pdp_rise(pins_s2_r.serial_load_wr, pins_s3_r.serial_load_wr)) begin
          primary_nxt   = shift_word_r; // see RULE14
          secondary_nxt = shift_word_r; // see RULE16
        end else if (pdp_rise(pins_s2_r.hop_wr, pins_s3_r.hop_wr)) begin
          secondary_nxt = primary_r; // see RULE16
        end
        if (pdp_rise(pins_s3_r.enh_wr, pins_s2_r.enh_wr)) begin
          enh_nxt = shift_enh_r; // see RULE19
        end
      end
      default: begin
      end
    endcase
    enh_act = pins_s2_r.enh_enable_n ? pdp_enh_s'(PDP_ENH_RST) : enh_r; // see RULE13
    case (mode)
      PDP_MODE_PARALLEL: use_primary = pins_s2_r.par_pp_sel | enh_act.counter_load; // see RULE11
      PDP_MODE_SERIAL:   use_primary = pins_s2_r.ser_pp_sel | enh_act.counter_load; // see RULE17
      default:           use_primary = 1'b0;
    endcase
    active_nxt = use_primary ? primary_r : secondary_r; // see RULE22
    if (mode == PDP_MODE_DIRECT) begin
      active_nxt.r_hi   = PDP_FORCED_ZERO; // see RULE21
      active_nxt.m_hi   = PDP_FORCED_ZERO; // see RULE21
      active_nxt.bypass = pins_s2_r.direct.bypass; // see RULE20
      active_nxt.m_lo   = pins_s2_r.direct.m_lo; // see RULE20
      active_nxt.r_lo   = pins_s2_r.direct.r_lo; // see RULE20
      active_nxt.a      = pins_s2_r.direct.a; // see RULE20
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      primary_r   <= PDP_WORD_RST;
      secondary_r <= PDP_WORD_RST;
      enh_r       <= PDP_ENH_RST;
      active_r    <= PDP_WORD_RST;
    end else begin
      primary_r   <= primary_nxt;
      secondary_r <= secondary_nxt;
      enh_r       <= enh_nxt;
      active_r    <= active_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain

  localparam logic [3:0] PRESC_LOW_LAST  = 4'(PDP_PRESC_LOW_RATIO - 4'h1);
  localparam logic [3:0] PRESC_HIGH_LAST = 4'(PDP_PRESC_HIGH_RATIO - 4'h1);

  logic [PDP_M_W-1:0] m_set;
  logic [PDP_R_W-1:0] r_set;
  logic [PDP_A_W-1:0] a_set;
  logic               rf_edge;
  logic               ref_edge;
  logic               modsel;
  logic               presc_tick;
  logic               main_end;
  logic               ref_end;
  logic               halt;
  logic [3:0]         presc_cnt_r;
  logic [3:0]         presc_cnt_nxt;
  logic [PDP_A_W-1:0] swallow_cnt_r;
  logic [PDP_A_W-1:0] swallow_cnt_nxt;
  logic [PDP_M_W-1:0] main_cnt_r;
  logic [PDP_M_W-1:0] main_cnt_nxt;
  logic [PDP_R_W-1:0] ref_cnt_r;
  logic [PDP_R_W-1:0] ref_cnt_nxt;
  logic               main_out_nxt;
  logic               comp_out_nxt;
  logic               modsel_out_nxt;
  logic               test_out_nxt;

  always_comb begin
    m_set           = {active_r.m_hi, active_r.m_lo};
    r_set           = {active_r.r_hi, active_r.r_lo};
    a_set           = active_r.a;
    halt            = enh_act.power_down; // see RULE22
    rf_edge         = pdp_rise(pins_s2_r.rf, pins_s3_r.rf) & ~halt;
    ref_edge        = pdp_rise(pins_s2_r.reference, pins_s3_r.reference) & ~halt;
    modsel          = ~active_r.bypass & (swallow_cnt_r < a_set); // see RULE23
    presc_cnt_nxt   = presc_cnt_r;
    presc_tick      = 1'b0;
    if (active_r.bypass) begin
      presc_cnt_nxt = '0; // see RULE2
      presc_tick    = rf_edge; // see RULE2 RULE5
    end else if (rf_edge) begin
      if (presc_cnt_r >= (modsel ? PRESC_HIGH_LAST : PRESC_LOW_LAST)) begin
        presc_cnt_nxt = '0; // see RULE1
        presc_tick    = 1'b1;
      end else begin
        presc_cnt_nxt = presc_cnt_r + 4'h1;
      end
    end
    main_end        = presc_tick & (main_cnt_r >= m_set); // see RULE3 RULE4
    main_cnt_nxt    = main_cnt_r;
    swallow_cnt_nxt = swallow_cnt_r;
    if (main_end) begin
      main_cnt_nxt    = '0;
      swallow_cnt_nxt = '0; // see RULE23
    end else if (presc_tick) begin
      main_cnt_nxt = main_cnt_r + 9'h001;
      if (modsel) begin
        swallow_cnt_nxt = swallow_cnt_r + 4'h1; // see RULE23
      end
    end
    ref_end     = ref_edge & (ref_cnt_r >= r_set); // see RULE6
    ref_cnt_nxt = ref_cnt_r;
    if (ref_end) begin
      ref_cnt_nxt = '0;
    end else if (ref_edge) begin
      ref_cnt_nxt = ref_cnt_r + 6'h01;
    end
    if (halt) begin
      presc_cnt_nxt   = '0;
      swallow_cnt_nxt = '0;
      main_cnt_nxt    = '0;
      ref_cnt_nxt     = '0;
    end
    main_out_nxt   = main_end & ~enh_act.out_disable; // see RULE22
    comp_out_nxt   = ref_end & ~enh_act.out_disable; // see RULE22
    modsel_out_nxt = modsel & ~halt;
    if (enh_act.modsel_out) begin
      test_out_nxt = modsel_out_nxt; // see RULE22
    end else if (enh_act.presc_out) begin
      test_out_nxt = presc_tick; // see RULE22
    end else begin
      test_out_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_cnt_r           <= '0;
      swallow_cnt_r         <= '0;
      main_cnt_r            <= '0;
      ref_cnt_r             <= '0;
      main_divided_output_o <= 1'b0;
      comparison_output_o   <= 1'b0;
      modulus_select_o      <= 1'b0;
      test_output_o         <= 1'b0;
    end else begin
      presc_cnt_r           <= presc_cnt_nxt;
      swallow_cnt_r         <= swallow_cnt_nxt;
      main_cnt_r            <= main_cnt_nxt;
      ref_cnt_r             <= ref_cnt_nxt;
      main_divided_output_o <= main_out_nxt;
      comparison_output_o   <= comp_out_nxt;
      modulus_select_o      <= modsel_out_nxt;
      test_output_o         <= test_out_nxt;
    end
  end

endmodule

// >>> dv/pdp_divider_core_assertions.sv
// Port-level checks for the divider programming block
`timescale 1ns/1ps

module pdp_divider_core_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rf_i,
  input wire logic enh_enable_n_i,
  input wire logic main_divided_output_o,
  input wire logic comparison_output_o,
  input wire logic modulus_select_o,
  input wire logic test_output_o
);
  logic [7:0] rf_cnt_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // RF edges since the last main pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rf_cnt_r <= 8'h00;
    end else if (main_divided_output_o) begin
      rf_cnt_r <= 8'h00;
    end else if ($rose(rf_i) && rf_cnt_r != 8'hFF) begin
      rf_cnt_r <= rf_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  main_gap_a: assert property (main_divided_output_o |=> (!main_divided_output_o)[*5])
    else $error("main pulses too close");
  cmp_gap_a: assert property (comparison_output_o |=> (!comparison_output_o)[*2])
    else $error("comparison pulses too close");
  main_rf_a: assert property (main_divided_output_o |-> rf_cnt_r >= 8'h01)
    else $error("main pulse without rf edges");
  modsel_hold_a: assert property ($rose(modulus_select_o) |=> modulus_select_o[*8])
    else $error("modulus select high too short");
  modsel_rest_a: assert property ($fell(modulus_select_o) |=> (!modulus_select_o)[*8])
    else $error("modulus select low too short");
  tst_off_a: assert property (enh_enable_n_i[*4] |-> !test_output_o)
    else $error("test output active while disabled");
  rst_div_a: assert property ($fell(rst_i) |-> !main_divided_output_o && !comparison_output_o)
    else $error("divider output after reset");
  rst_test_a: assert property ($fell(rst_i) |-> !modulus_select_o && !test_output_o)
    else $error("test output after reset");
endmodule

// >>> dv/pdp_host_model.sv
// Host controller model driving strobes, parallel bus and serial link
`timescale 1ns/1ps

module pdp_host_model (
  input  wire logic       clk_i,
  output logic            sclk_o,
  output logic            sdata_o,
  output logic [7:0]      data_o,
  output logic [5:0]      stb_o
);
  initial begin
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
    data_o  = 8'h00;
    stb_o   = 6'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe high and low for five system cycles each
  task automatic pulse(input int s);
    repeat (5) @(negedge clk_i);
    stb_o[s] = 1'b1;
    repeat (5) @(negedge clk_i);
    stb_o[s] = 1'b0;
    repeat (5) @(negedge clk_i);
  endtask

  task automatic par(input int s, input logic [7:0] v);
    @(negedge clk_i);
    data_o = v;
    pulse(s);
    data_o = ~v;
  endtask

  // Link clock of 12 ns, still between frames
  task automatic shift(input logic [19:0] v, input int n);
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      sdata_o = v[i];
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    sdata_o = ~sdata_o;
  endtask

  task automatic word(input logic [19:0] w);
    shift(w, 20);
    repeat (5) @(negedge clk_i);
    pulse(5);
  endtask

  task automatic enh(input logic [7:0] b);
    @(negedge clk_i);
    stb_o[4] = 1'b1;
    repeat (5) @(negedge clk_i);
    shift({12'h000, b}, 8);
    repeat (5) @(negedge clk_i);
    stb_o[4] = 1'b0;
    repeat (5) @(negedge clk_i);
  endtask
endmodule

// >>> dv/pdp_divider_core_tb.sv
// Self-checking bench for the divider programming block
`timescale 1ns/1ps

`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, a); end end

module pdp_divider_core_tb;
  import pdp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        rf    = 1'b0;
  logic [1:0]  ph    = 2'h0;
  logic        bmode = 1'b0;
  logic        smode = 1'b0;
  logic        ppp   = 1'b1;
  logic        pps   = 1'b1;
  logic        enh_n = 1'b1;
  pdp_direct_s dset  = '0;
  pdp_word_s   w;
  logic        sclk, sdata, mdo, cmp, ms, tst;
  logic [7:0]  data;
  logic [5:0]  stb;
  logic [1:0]  pul;
  int          failures = 0;
  int          total_checks = 0;
  int          k, t, p, h, wd;

  assign pul = {cmp, mdo};
  always #5 clk_i = ~clk_i;
  // RF and reference edges every four cycles
  always @(negedge clk_i) begin
    ph <= ph + 2'h1;
    rf <= ph[1];
  end

  pdp_host_model u_pdp_host_model (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata),
    .data_o(data), .stb_o(stb));

  pdp_divider_core u_pdp_divider_core (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk),
    .serial_data_i(sdata), .bus_mode_i(bmode), .serial_select_i(smode), .data_i(data),
    .main_low_write_strobe_i(stb[0]), .main_high_write_strobe_i(stb[1]),
    .swallow_ref_write_strobe_i(stb[2]), .hop_write_strobe_i(stb[3]),
    .enh_write_strobe_i(stb[4]), .serial_load_strobe_i(stb[5]),
    .parallel_pingpong_select_i(ppp), .serial_pingpong_select_i(pps),
    .enh_enable_n_i(enh_n), .direct_setting_i(dset), .rf_i(rf), .reference_input_i(rf),
    .main_divided_output_o(mdo), .comparison_output_o(cmp), .modulus_select_o(ms),
    .test_output_o(tst));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Period in cycles between pulses, first two periods skipped
  task automatic per(input int f, input int exp, input string nm);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (pul[f] !== 1'b1 && n < 20000);
    end
    `CHK(nm, exp, n)
    if (n >= 20000) begin
      stop_test();
    end
  endtask

  task automatic watch();
    k = 0;
    t = 0;
    p = 0;
    h = 0;
    wd = 0;
    repeat (5600) begin
      @(negedge clk_i);
      k += int'(tst !== ms);
      t += int'(tst === 1'b1);
      p += int'(mdo === 1'b1);
      if (ms === 1'b1) begin
        h++;
      end else if (h > 0) begin
        wd = (h > wd) ? h : wd;
        h = 0;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_par();
    u_pdp_host_model.par(0, 8'h01);
    u_pdp_host_model.par(1, 8'h00);
    u_pdp_host_model.par(2, 8'h32);
    u_pdp_host_model.pulse(3);
    per(0, 88, "par_main");
    per(1, 16, "par_cmp");
    $display("t_par done");
  endtask

  task automatic t_hop();
    ppp = 1'b0;
    u_pdp_host_model.par(0, 8'h85);
    per(0, 88, "sec_main");
    ppp = 1'b1;
    per(0, 24, "byp_main");
    u_pdp_host_model.pulse(3);
    ppp = 1'b0;
    per(0, 24, "hop_main");
    $display("t_hop done");
  endtask

  task automatic t_ser();
    smode = 1'b1;
    pps = 1'b0;
    w = '{r_hi:2'h1, m_hi:2'h1, bypass:1'b0, m_lo:7'h00, r_lo:4'h0, a:4'h3};
    u_pdp_host_model.word(w);
    per(0, 5172, "ser_main");
    per(1, 68, "ser_cmp");
    $display("t_ser done");
  endtask

  task automatic t_enh();
    enh_n = 1'b0;
    u_pdp_host_model.enh(8'h05);
    repeat (3) @(negedge clk_i);
    watch();
    `CHK("tst_ms", 0, k)
    `CHK("main_off", 0, p)
    `CHK("ms_wide", 132, wd)
    enh_n = 1'b1;
    repeat (5) @(negedge clk_i);
    watch();
    `CHK("tst_off", 0, t)
    `CHK("main_on", 1, p > 0)
    $display("t_enh done");
  endtask

  task automatic t_dir();
    bmode = 1'b1;
    dset = '{bypass:1'b1, m_lo:7'h03, r_lo:4'h1, a:4'h0};
    u_pdp_host_model.par(0, 8'hFF);
    per(0, 16, "dir_main");
    per(1, 8, "dir_cmp");
    $display("t_dir done");
  endtask

  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge clk_i);
    t_par();
    t_hop();
    t_ser();
    t_enh();
    t_dir();
    stop_test();
  end
endmodule

bind pdp_divider_core pdp_divider_core_checker u_pdp_divider_core_checker (
  .clk_i(clk_i), .rst_i(rst_i), .rf_i(rf_i), .enh_enable_n_i(enh_enable_n_i),
  .main_divided_output_o(main_divided_output_o),
  .comparison_output_o(comparison_output_o),
  .modulus_select_o(modulus_select_o), .test_output_o(test_output_o));
